// file: hw/fpr_engine.sv
// Fringe phase, rotation, window, phase ramp and output drive of one transform engine.
// Assumes an APB master and the butterfly stages all run on pclk.
// Notes on behaviour
// [R1] Initial phase and rate, 40 bits each, reload at a fixed interval.
// [R2] Phase advances by the rate every clock cycle.
// [R3] Only the top eight phase bits drive rotation, truncated.
// [R4] Phase and sample code address a 1K table of rotated samples.
// [R5] Table entries are 7,7,2 complex values.
// [R6] Table contents also map sample codes to binary weights.
// [R7] First-stage twiddle port carries window weights.
// [R8] Window weights are real and non-negative, 5,0,4 format.
// [R9] External bit-reversed address writes the first-stage buffer.
// [R10] Later stages get 5,5,0 twiddles without exponent.
// [R11] Twiddle tables cycle; whole passes per integration period.
// [R12] A new 20-bit slope arrives at a fixed cycle interval.
// [R13] Final-stage point N is rotated by N slopes, first by zero.
// [R14] Paired engines swap points before their last stage.
// [R15] A card's engines take adjacent channels of adjacent stations.
// [R16] Data move as 7,7,4 and leave reduced to 4,4,4.
// [R17] Output points leave at most one every two cycles.
// [R18] Polarization mode limits transforms to 512 points.
// [R19] Oscillator is chained 10-bit slices, serial load, pipelined carry.
// [R20] Complex values are sign-magnitude pairs with a shared exponent.
// [R21] Phase wraps modulo two to the fortieth; reload is atomic.
// [R22] A new slope takes effect only at a spectrum start.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fpr_engine import fpr_pkg::*; #(
  parameter int unsigned COEF_CYC = COEF_RELOAD_CYC // Cycles before coefficients go stale.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic smp_valid, // Sample strobe.
  input wire logic [1:0] smp_code, // Raw sample code.
  input wire logic [LUT_AW-1:0] smp_addr, // Bit-reversed buffer address.
  input wire fpr_win_t smp_win, // Window weight for this sample.
  output logic s1_valid_q, // First-stage point strobe.
  output logic [LUT_AW-1:0] s1_addr_q, // First-stage buffer address.
  output fpr_c772_t s1_point, // Rotated sample to first stage.
  output fpr_win_t s1_twid_q, // First-stage twiddle (window weight).
  input wire logic spec_end, // Pulse at the end of each spectrum.
  input wire logic integ_start, // Pulse at each integration period start.
  output logic [TAB_W-1:0] tw_tab_q, // Twiddle table selector.
  input wire logic fin_valid, // Point strobe into the final stage.
  input wire logic fin_first, // First point of a spectrum.
  input wire logic fin_swap, // Take the partner's point here.
  input wire fpr_c774_t fin_point, // Own point for the final stage.
  input wire fpr_c774_t pair_point, // Partner engine's point.
  output logic xchg_valid_q, // Point strobe to the partner.
  output fpr_c774_t xchg_point_q, // Point to the partner.
  output logic rot_valid_q, // Ramped point strobe.
  output fpr_c774_t rot_point_q, // Point to rotate in the final stage.
  output logic [SLOPE_W-1:0] rot_phase, // Ramp phase for that point.
  input wire logic fst_valid, // Final-stage output strobe.
  input wire fpr_c774_t fst_point, // Final-stage output point.
  output logic xm_valid_q, // Strobe to the cross multipliers.
  output fpr_c444_t xm_point_q // Reduced point to the cross multipliers.
);
  logic wr_en, rd_setup, acc_en, commit, slope_wr, lut_we, apply, step, emit;
  logic run_q, pol_q, pair_q, cfg_err_q, ovr_q, stale_q, pass_err_q;
  logic [3:0] size_q;
  logic [PH_W-1:0] pinit_q, rate_new_q, acc_q, rate_q;
  logic [31:0] rd_val, stale_cnt_q;
  logic [LUT_AW-1:0] lut_addr_q;
  logic [SLOPE_W-1:0] sh_q, slope_act;
  logic [3:0] sh_cnt_q;
  fpr_sl_state_t sl_q;
  logic [2:0] hi_ctl_q;
  logic [SLICE_W-1:0] lo_acc, hi_acc, lo_d_q, lo_rate, hi_rate;
  logic lo_cout, pend_q, gap_q, d1_valid_q;
  fpr_c774_t d1_pt_q;
  fpr_c444_t pend_pt_q;

  function automatic logic addr_ok(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_PINIT_LO || a == OFS_PINIT_HI ||
      a == OFS_RATE_LO || a == OFS_RATE_HI || a == OFS_COMMIT || a == OFS_SLOPE ||
      a == OFS_LUT_ADDR || a == OFS_LUT_DATA || a == OFS_STATUS;
  endfunction

  function automatic logic wr_at(input logic en, input logic [7:0] a, input logic [7:0] o);
    return en && a == o;
  endfunction

  // Dropping three magnitude bits is made up by the exponent, saturating at the top.
  function automatic fpr_c444_t reduce(input fpr_c774_t p);
    fpr_c444_t r;
    r.re = {p.re[6], p.re[5:3]}; // R20
    r.im = {p.im[6], p.im[5:3]};
    r.ex = (p.ex > EXP_MAX - EXP_ADJ) ? EXP_MAX : p.ex + EXP_ADJ;
    return r;
  endfunction

  // Zero wait states: writes land at the access edge, reads are fetched at setup.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && addr_ok(paddr);
  assign rd_setup = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign commit = wr_at(wr_en, paddr, OFS_COMMIT) && pwdata[0];
  assign slope_wr = wr_at(wr_en, paddr, OFS_SLOPE) && sl_q == SL_IDLE;
  assign lut_we = wr_at(wr_en, paddr, OFS_LUT_DATA);
  assign acc_en = run_q;

  always_comb begin
    rd_val = '0;
    unique case (paddr)
      OFS_CTRL: rd_val[CTRL_SIZE+3:0] = {size_q, pair_q, pol_q, run_q};
      OFS_PINIT_LO: rd_val = pinit_q[31:0];
      OFS_PINIT_HI: rd_val[7:0] = pinit_q[PH_W-1:32];
      OFS_RATE_LO: rd_val = rate_new_q[31:0];
      OFS_RATE_HI: rd_val[7:0] = rate_new_q[PH_W-1:32];
      OFS_SLOPE: rd_val[SLOPE_W-1:0] = slope_act;
      OFS_LUT_ADDR: rd_val[LUT_AW-1:0] = lut_addr_q;
      OFS_STATUS: rd_val[ST_PASS:0] = {pass_err_q, stale_q, ovr_q, cfg_err_q,
        sl_q == SL_SHIFT, tw_tab_q, acc_q[PH_W-1 -: PH_ROT_W]};
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= rd_val;
    end
  end

  // A polarization setting above 512 points is refused whole.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      pol_q <= 1'b0;
      pair_q <= 1'b0;
      size_q <= SIZE_RST;
    end else if (wr_at(wr_en, paddr, OFS_CTRL) &&
        !(pwdata[CTRL_POL] && pwdata[CTRL_SIZE +: 4] > POL_MAX_LOG2)) begin // R18
      run_q <= pwdata[CTRL_RUN];
      pol_q <= pwdata[CTRL_POL];
      pair_q <= pwdata[CTRL_PAIR];
      size_q <= pwdata[CTRL_SIZE +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pinit_q <= '0;
      rate_new_q <= '0;
      lut_addr_q <= '0;
    end else begin
      if (wr_at(wr_en, paddr, OFS_PINIT_LO)) pinit_q[31:0] <= pwdata;
      if (wr_at(wr_en, paddr, OFS_PINIT_HI)) pinit_q[PH_W-1:32] <= pwdata[7:0]; // R1
      if (wr_at(wr_en, paddr, OFS_RATE_LO)) rate_new_q[31:0] <= pwdata;
      if (wr_at(wr_en, paddr, OFS_RATE_HI)) rate_new_q[PH_W-1:32] <= pwdata[7:0];
      if (wr_at(wr_en, paddr, OFS_LUT_ADDR)) begin
        lut_addr_q <= pwdata[LUT_AW-1:0];
      end else if (lut_we) begin
        lut_addr_q <= lut_addr_q + 1'b1;
      end
    end
  end

  // Phase and rate swap on one edge, so no cycle sees a mixed pair.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      rate_q <= '0;
    end else if (commit) begin
      acc_q <= pinit_q; // R21
      rate_q <= rate_new_q;
    end else if (acc_en) begin
      acc_q <= acc_q + rate_q; // R2 R21
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stale_cnt_q <= '0;
    end else if (commit) begin
      stale_cnt_q <= '0;
    end else if (stale_cnt_q < COEF_CYC) begin
      stale_cnt_q <= stale_cnt_q + 32'h00000001;
    end
  end

  // Software clears sticky flags by writing ones; a new event wins that cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_err_q <= 1'b0;
      ovr_q <= 1'b0;
      stale_q <= 1'b0;
      pass_err_q <= 1'b0;
    end else begin
      if (wr_at(wr_en, paddr, OFS_STATUS)) begin
        cfg_err_q <= cfg_err_q & ~pwdata[ST_CFG];
        ovr_q <= ovr_q & ~pwdata[ST_OVR];
        stale_q <= stale_q & ~pwdata[ST_STALE];
        pass_err_q <= pass_err_q & ~pwdata[ST_PASS];
      end
      if (wr_at(wr_en, paddr, OFS_CTRL) && pwdata[CTRL_POL] &&
          pwdata[CTRL_SIZE +: 4] > POL_MAX_LOG2) cfg_err_q <= 1'b1; // R18
      if (fst_valid && pend_q && !emit) ovr_q <= 1'b1;
      if (run_q && stale_cnt_q == COEF_CYC - 1) stale_q <= 1'b1; // R1
      if (integ_start && tw_tab_q != '0) pass_err_q <= 1'b1; // R11
    end
  end

  fpr_rot_lut u_lut (
    .pclk(pclk),
    .presetn(presetn),
    .we(lut_we),
    .waddr(lut_addr_q),
    .wdata(pwdata[15:0]),
    .raddr({acc_q[PH_W-1 -: PH_ROT_W], smp_code}), // R3 R4 R5 R6
    .rdata_q(s1_point)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_valid_q <= 1'b0;
      s1_addr_q <= '0;
      s1_twid_q <= '0;
    end else begin
      s1_valid_q <= smp_valid;
      s1_addr_q <= smp_addr; // R9
      s1_twid_q <= smp_win.mant[4] ? '0 : smp_win; // R7 R8
    end
  end

  // Realigning to table zero keeps each integration on whole passes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tw_tab_q <= '0;
    end else if (integ_start) begin
      tw_tab_q <= '0; // R11
    end else if (spec_end) begin
      tw_tab_q <= tw_tab_q + 1'b1; // R10 R11
    end
  end

  // Serial load of the slope into both slices, ten bits each, low bits first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sl_q <= SL_IDLE;
      sh_q <= '0;
      sh_cnt_q <= '0;
    end else begin
      unique case (sl_q)
        SL_IDLE: if (slope_wr) begin
          sh_q <= pwdata[SLOPE_W-1:0]; // R12
          sh_cnt_q <= '0;
          sl_q <= SL_SHIFT;
        end
        SL_SHIFT: begin
          sh_q <= {1'b0, sh_q[SLOPE_W-1:SLICE_W+1], 1'b0, sh_q[SLICE_W-1:1]};
          sh_cnt_q <= sh_cnt_q + 1'b1;
          if (sh_cnt_q == SHIFT_LAST) sl_q <= SL_IDLE; // R19
        end
        default: sl_q <= SL_IDLE;
      endcase
    end
  end

  // A half-loaded slope never applies; the old one stays for that spectrum.
  assign apply = fin_valid && fin_first && sl_q == SL_IDLE; // R22
  assign step = fin_valid && !fin_first;
  assign slope_act = {hi_rate, lo_rate};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_ctl_q <= '0;
      lo_d_q <= '0;
    end else begin
      hi_ctl_q <= {apply, fin_valid && fin_first, step}; // R19
      lo_d_q <= lo_acc;
    end
  end

  fpr_osc_slice u_lo (
    .pclk(pclk),
    .presetn(presetn),
    .ld_en(sl_q == SL_SHIFT),
    .ld_bit(sh_q[0]),
    .apply(apply),
    .clear(fin_valid && fin_first), // R13
    .step(step),
    .cin(1'b0),
    .acc_q(lo_acc),
    .rate_q(lo_rate),
    .cout_q(lo_cout)
  );

  fpr_osc_slice u_hi (
    .pclk(pclk),
    .presetn(presetn),
    .ld_en(sl_q == SL_SHIFT),
    .ld_bit(sh_q[SLICE_W]),
    .apply(hi_ctl_q[2]),
    .clear(hi_ctl_q[1]),
    .step(hi_ctl_q[0]),
    .cin(lo_cout),
    .acc_q(hi_acc),
    .rate_q(hi_rate),
    .cout_q()
  );

  assign rot_phase = {hi_acc, lo_d_q}; // R13

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d1_valid_q <= 1'b0;
      d1_pt_q <= '0;
      rot_valid_q <= 1'b0;
      rot_point_q <= '0;
      xchg_valid_q <= 1'b0;
      xchg_point_q <= '0;
    end else begin
      d1_valid_q <= fin_valid;
      d1_pt_q <= (pair_q && fin_swap) ? pair_point : fin_point; // R14
      rot_valid_q <= d1_valid_q;
      rot_point_q <= d1_pt_q;
      xchg_valid_q <= fin_valid && pair_q; // R14
      xchg_point_q <= fin_point;
    end
  end

  assign emit = pend_q && !gap_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      pend_pt_q <= '0;
      gap_q <= 1'b0;
      xm_valid_q <= 1'b0;
      xm_point_q <= '0;
    end else begin
      pend_q <= fst_valid || (pend_q && !emit);
      if (fst_valid) pend_pt_q <= reduce(fst_point); // R16
      gap_q <= emit; // R17
      xm_valid_q <= emit;
      if (emit) xm_point_q <= pend_pt_q;
    end
  end

  AST_PHASE_STEP: assert property (@(posedge pclk) disable iff (!presetn) // R2
    run_q && !commit |=> acc_q == $past(acc_q) + $past(rate_q))
    else $error("phase did not advance by the rate");
  AST_COMMIT: assert property (@(posedge pclk) disable iff (!presetn) // R21
    commit |=> acc_q == $past(pinit_q) && rate_q == $past(rate_new_q))
    else $error("coefficient reload not atomic");
  AST_S1_ADDR: assert property (@(posedge pclk) disable iff (!presetn) // R9
    smp_valid |=> s1_valid_q && s1_addr_q == $past(smp_addr))
    else $error("first-stage address lost");
  AST_WIN_POS: assert property (@(posedge pclk) disable iff (!presetn) // R8
    s1_valid_q |-> !s1_twid_q.mant[4])
    else $error("negative window weight");
  AST_RAMP_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R13
    fin_valid && fin_first |-> ##2 rot_valid_q && rot_phase == '0)
    else $error("first point not at zero phase");
  AST_SLOPE_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R22
    !hi_ctl_q[2] && !apply |=> lo_rate == $past(lo_rate))
    else $error("slope changed inside a spectrum");
  AST_PACE: assert property (@(posedge pclk) disable iff (!presetn) // R17
    xm_valid_q |=> !xm_valid_q)
    else $error("output faster than one point per two cycles");
  AST_POL_SIZE: assert property (@(posedge pclk) disable iff (!presetn) // R18
    pol_q |-> size_q <= POL_MAX_LOG2)
    else $error("polarization transform too large");
  AST_REDUCE: assert property (@(posedge pclk) disable iff (!presetn) // R16
    fst_valid && !pend_q ##1 1'b1 |=> xm_valid_q && xm_point_q == reduce($past(fst_point, 2)))
    else $error("output reduction wrong");
  AST_TAB_WRAP: assert property (@(posedge pclk) disable iff (!presetn) // R11
    integ_start |=> tw_tab_q == '0)
    else $error("table pass not realigned");
  COV_COMMIT: cover property (@(posedge pclk) disable iff (!presetn) commit ##1 run_q);
  COV_RAMP: cover property (@(posedge pclk) disable iff (!presetn)
    fin_valid && fin_first ##2 fin_valid ##2 rot_valid_q);
  COV_PAIR: cover property (@(posedge pclk) disable iff (!presetn) fin_valid && fin_swap && pair_q);
  COV_OUT: cover property (@(posedge pclk) disable iff (!presetn) xm_valid_q ##2 xm_valid_q);
endmodule
`default_nettype wire

// file: hw/fpr_pkg.sv
// Shared constants, field layouts and types of the engine's phase rotation block.
// Assumes a single clock; every other file imports this package whole.
package fpr_pkg;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned COEF_RELOAD_NS = 4000000;
  localparam int unsigned COEF_RELOAD_CYC = COEF_RELOAD_NS / CLK_NS;
  localparam int PH_W = 40;
  localparam int PH_ROT_W = 8;
  localparam int SLOPE_W = 20;
  localparam int SLICE_W = 10;
  localparam int LUT_AW = 10;
  localparam int LUT_DEPTH = 1024;
  localparam int TAB_W = 5;
  localparam logic [3:0] POL_MAX_LOG2 = 4'h9;
  localparam logic [3:0] SIZE_RST = 4'hA;
  localparam logic [3:0] SHIFT_LAST = 4'h9;
  localparam logic [3:0] EXP_MAX = 4'hF;
  localparam logic [3:0] EXP_ADJ = 4'h3;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PINIT_LO = 8'h04;
  localparam logic [7:0] OFS_PINIT_HI = 8'h08;
  localparam logic [7:0] OFS_RATE_LO = 8'h0C;
  localparam logic [7:0] OFS_RATE_HI = 8'h10;
  localparam logic [7:0] OFS_COMMIT = 8'h14;
  localparam logic [7:0] OFS_SLOPE = 8'h18;
  localparam logic [7:0] OFS_LUT_ADDR = 8'h1C;
  localparam logic [7:0] OFS_LUT_DATA = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // Control and status field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_POL = 1;
  localparam int CTRL_PAIR = 2;
  localparam int CTRL_SIZE = 3;
  localparam int ST_TAB = 8;
  localparam int ST_BUSY = 13;
  localparam int ST_CFG = 14;
  localparam int ST_OVR = 15;
  localparam int ST_STALE = 16;
  localparam int ST_PASS = 17;
  // Sign-magnitude complex formats (real, imaginary, shared exponent), then the real window weight and the slope load states.
  typedef struct packed {
    logic [6:0] re;
    logic [6:0] im;
    logic [3:0] ex;
  } fpr_c774_t;
  typedef struct packed {
    logic [6:0] re;
    logic [6:0] im;
    logic [1:0] ex;
  } fpr_c772_t;
  typedef struct packed {
    logic [3:0] re;
    logic [3:0] im;
    logic [3:0] ex;
  } fpr_c444_t;
  typedef struct packed {
    logic [4:0] mant;
    logic [3:0] ex;
  } fpr_win_t;
  typedef enum logic [1:0] {SL_IDLE = 2'b01, SL_SHIFT = 2'b10} fpr_sl_state_t;
endpackage

// file: hw/fpr_rot_lut.sv
// Rotation look-up table: phase and sample code in, rotated sample out.
// Assumes software fills the table before the engine runs.
`timescale 1ns/1ns
`default_nettype none
module fpr_rot_lut import fpr_pkg::*; (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic we, // Table write strobe.
  input wire logic [LUT_AW-1:0] waddr, // Table write index.
  input wire logic [15:0] wdata, // Table write data.
  input wire logic [LUT_AW-1:0] raddr, // Phase and sample index.
  output fpr_c772_t rdata_q // Rotated sample, one cycle later.
);
  logic [15:0] mem [LUT_DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// file: hw/fpr_osc_slice.sv
// One ten-bit slice of the phase ramp oscillator with a registered carry out.
// Assumes the next slice up runs its controls one cycle later than this one.
`timescale 1ns/1ns
`default_nettype none
module fpr_osc_slice import fpr_pkg::*; (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic ld_en, // Shift one rate bit into the holding register.
  input wire logic ld_bit, // Serial rate bit, least significant first.
  input wire logic apply, // Copy holding register to the active rate.
  input wire logic clear, // Zero the phase and the carry.
  input wire logic step, // Add the active rate once.
  input wire logic cin, // Carry from the slice below.
  output logic [SLICE_W-1:0] acc_q, // Phase slice.
  output logic [SLICE_W-1:0] rate_q, // Active rate slice.
  output logic cout_q // Registered carry to the slice above.
);
  logic [SLICE_W-1:0] hold_q;
  logic [SLICE_W:0] sum;

  assign sum = {1'b0, acc_q} + {1'b0, (step ? rate_q : '0)} + {{SLICE_W{1'b0}}, cin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= '0;
    end else if (ld_en) begin
      hold_q <= {ld_bit, hold_q[SLICE_W-1:1]}; // R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q <= '0;
    end else if (apply) begin
      rate_q <= hold_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      cout_q <= 1'b0;
    end else if (clear) begin
      acc_q <= '0;
      cout_q <= 1'b0;
    end else begin
      acc_q <= sum[SLICE_W-1:0];
      cout_q <= sum[SLICE_W]; // R19
    end
  end
endmodule
`default_nettype wire

// file: sim/fpr_pair_model.sv
// Model of the paired engine that feeds points across the cross link before the last stage.
// Assumes the engine samples pair_point on the rising edge of pclk.
`timescale 1ns/1ns
`default_nettype none
module fpr_pair_model import fpr_pkg::*; (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Asynchronous reset, active low.
  output fpr_c774_t pair_point // Partner's point, new every cycle.
);
  // A fresh point every cycle, so a capture on the wrong edge shows as a mismatch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_point <= fpr_c774_t'(18'h2AAAA);
    end else begin
      pair_point <= fpr_c774_t'(pair_point + 18'h0A5A1);
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_fpr_engine.sv
// Self-checking bench for the phase rotation engine: registers, sample path, ramp, output.
// Assumes fpr_pkg, the design files and the partner model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_fpr_engine;
  import fpr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic smp_valid = 1'b0, spec_end = 1'b0, integ_start = 1'b0, fst_valid = 1'b0;
  logic fin_valid = 1'b0, fin_first = 1'b0, fin_swap = 1'b0;
  logic [1:0] smp_code = 2'h0;
  logic [LUT_AW-1:0] smp_addr = '0, s1_addr_q;
  fpr_win_t smp_win = '0, s1_twid_q;
  fpr_c774_t fin_point = '0, fst_point = '0, pair_point, xchg_point_q, rot_point_q, pp;
  fpr_c772_t s1_point;
  fpr_c444_t xm_point_q;
  logic s1_valid_q, xchg_valid_q, rot_valid_q, xm_valid_q;
  logic [TAB_W-1:0] tw_tab_q;
  logic [SLOPE_W-1:0] rot_phase;
  int bad_count = 0, n_compared = 0;

  fpr_engine #(.COEF_CYC(50)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_valid(smp_valid), .smp_code(smp_code), .smp_addr(smp_addr), .smp_win(smp_win),
    .s1_valid_q(s1_valid_q), .s1_addr_q(s1_addr_q), .s1_point(s1_point),
    .s1_twid_q(s1_twid_q), .spec_end(spec_end), .integ_start(integ_start),
    .tw_tab_q(tw_tab_q), .fin_valid(fin_valid), .fin_first(fin_first), .fin_swap(fin_swap),
    .fin_point(fin_point), .pair_point(pair_point), .xchg_valid_q(xchg_valid_q),
    .xchg_point_q(xchg_point_q), .rot_valid_q(rot_valid_q), .rot_point_q(rot_point_q),
    .rot_phase(rot_phase), .fst_valid(fst_valid), .fst_point(fst_point),
    .xm_valid_q(xm_valid_q), .xm_point_q(xm_point_q)
  );
  fpr_pair_model partner (.pclk(pclk), .presetn(presetn), .pair_point(pair_point));

  initial begin
    forever #20 pclk = ~pclk;
  end

  task automatic final_report;
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask

  // The request is held until pready is seen high; data and error are taken on that edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      bad_count++;
      final_report();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic t_regs;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h50, rd);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, OFS_PINIT_LO, 32'h0);
    apb(1'b1, OFS_PINIT_HI, 32'h12);
    apb(1'b1, OFS_RATE_LO, 32'h0);
    apb(1'b1, OFS_RATE_HI, 32'h0);
    apb(1'b1, OFS_COMMIT, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h51);
    apb(1'b1, OFS_CTRL, 32'h53);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl refused", 32'h51, rd);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("phase top", 32'h12, {24'h0, rd[7:0]});
    chk("config error", 32'h1, {31'h0, rd[ST_CFG]});
  endtask

  task automatic t_sample;
    apb(1'b1, OFS_LUT_ADDR, 32'h4A);
    apb(1'b1, OFS_LUT_DATA, 32'hABCD);
    @(posedge pclk);
    smp_valid <= 1'b1;
    smp_code <= 2'h2;
    smp_addr <= 10'h3C1;
    smp_win <= fpr_win_t'(9'h0B3);
    @(posedge pclk);
    smp_win <= fpr_win_t'(9'h132);
    @(posedge pclk);
    smp_valid <= 1'b0;
    chk("s1 valid", 32'h1, {31'h0, s1_valid_q});
    chk("s1 point", 32'hABCD, {16'h0, s1_point});
    chk("s1 addr", 32'h3C1, {22'h0, s1_addr_q});
    chk("s1 twiddle", 32'h0B3, {23'h0, s1_twid_q});
    @(posedge pclk);
    chk("s1 twiddle negative", 32'h0, {23'h0, s1_twid_q});
  endtask

  task automatic t_table;
    int k;
    for (k = 0; k < 3; k++) begin
      @(posedge pclk);
      spec_end <= 1'b1;
      @(posedge pclk);
      spec_end <= 1'b0;
    end
    repeat (2) @(posedge pclk);
    chk("table", 32'h3, {27'h0, tw_tab_q});
    integ_start <= 1'b1;
    @(posedge pclk);
    integ_start <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("table restart", 32'h0, {27'h0, tw_tab_q});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("pass error", 32'h1, {31'h0, rd[ST_PASS]});
  endtask

  task automatic t_ramp;
    int k;
    apb(1'b1, OFS_CTRL, 32'h55);
    apb(1'b1, OFS_SLOPE, 32'h5);
    for (k = 0; k < 40; k++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if (rd[ST_BUSY] === 1'b0) break;
    end
    if (k == 40) begin
      bad_count++;
      final_report();
    end
    chk("coef stale", 32'h1, {31'h0, rd[ST_STALE]});
    // A loaded slope stays idle until the next spectrum start.
    apb(1'b0, OFS_SLOPE, 32'h0);
    chk("slope before start", 32'h0, rd);
    for (k = 0; k < 6; k++) begin
      @(posedge pclk);
      if (k == 1) pp = pair_point;
      if (k == 2) chk("exchange", 32'h1, {14'h0, xchg_point_q});
      if (k == 2) chk("exchange valid", 32'h1, {31'h0, xchg_valid_q});
      if (k >= 3) chk("ramp valid", 32'h1, {31'h0, rot_valid_q});
      if (k == 3) chk("swapped", {14'h0, pp}, {14'h0, rot_point_q});
      if (k >= 3) chk("ramp", 32'((k - 3) * 5), {12'h0, rot_phase});
      fin_valid <= (k < 3);
      fin_first <= (k == 0);
      fin_swap <= (k == 0);
      fin_point <= fpr_c774_t'(18'(k * 3 + 1));
    end
    apb(1'b0, OFS_SLOPE, 32'h0);
    chk("slope", 32'h5, rd);
  endtask

  task automatic t_out;
    int k;
    logic prev;
    prev = 1'b0;
    for (k = 0; k < 8; k++) begin
      @(posedge pclk);
      if (k == 3) chk("xm point", 32'h5FF, {20'h0, xm_point_q});
      chk("xm spacing", 32'h0, {31'h0, prev & xm_valid_q});
      prev = xm_valid_q;
      fst_valid <= (k < 2);
      fst_point <= (k == 0) ? fpr_c774_t'(18'h147FE) : fpr_c774_t'(18'h00001);
    end
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sample();
    t_table();
    t_ramp();
    t_out();
    final_report();
  end
endmodule
`default_nettype wire
